/* verilog/irl_top.sv */
`timescale 1ns/1ps
`include "irl_cfg.svh"
// Contract
// - eight enable bits, one per primary source
// - primary requests latch until software clears
// - touch overflow and complete enables, bits 3:2
// - touch overflow and complete requests, bits 3:2
// - counter event edge, rising or falling
// - pin pair edge fields, both/rise/fall
// - event select picks counter bit 8..15
// - counter clock source decode
// - prescaler divides by 1, 4, 16, 64
// - pins 0 and 4 gate input, wake, request
// - pins 7,6,5,3 gate input and wake
module irl_top
    import irl_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [8:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic timer_three_evt_in,
    input wire logic timer_two_evt_in,
    input wire logic pwm_gen_zero_evt_in,
    input wire logic cmp_pwm_one_evt_in,
    input wire logic converter_done_in,
    input wire logic touch_overflow_in,
    input wire logic touch_complete_in,
    input wire logic [7:0] port_a_pins_in,
    input wire logic port_b_pin_zero_in,
    input wire logic port_b_pin_five_in,
    input wire logic fast_internal_osc_in,
    input wire logic slow_internal_osc_in,
    output logic irq_out,
    output logic wake_out,
    output logic [7:0] port_a_digital_out
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [7:0] en_pri_r;
    logic [7:0] req_pri_r;
    logic [7:0] req_pri_nxt;
    logic [7:0] c16_mode_r;
    logic [4:0] edge_sel_r;
    logic [7:0] pa_dier_r;
    logic [1:0] en_sec_r;
    logic [1:0] req_sec_r;
    logic [1:0] req_sec_nxt;
    logic [1:0] pair_sel_r;

    logic [`IRL_SYNC_W-1:0] async_pins;
    logic [`IRL_SYNC_W-1:0] sync1_r;
    logic [`IRL_SYNC_W-1:0] sync2_r;
    logic [`IRL_SYNC_W-1:0] sync3_r;

    logic [7:0] pa_gated;
    logic [7:0] pa_gated_prev;
    logic pair_a_now;
    logic pair_a_prev_r;
    logic pair_b_now;
    logic pair_b_prev_r;
    logic pair_a_evt;
    logic pair_b_evt;
    logic [7:0] pri_events;
    logic [1:0] sec_events;

    logic [6:0] idx;
    logic setup_ph;
    logic wr_acc;
    logic lane0_wr;
    logic hit;
    logic [7:0] rd_byte;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic irq_r;
    logic wake_r;
    logic [7:0] pa_dout_r;

    irl_cnt_if cnt_bus ();

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    assign async_pins = {slow_internal_osc_in, fast_internal_osc_in,
                         port_b_pin_five_in, port_b_pin_zero_in, port_a_pins_in};

    genvar gi;
    generate
        for (gi = 0; gi < `IRL_SYNC_W; gi = gi + 1) begin : g_sync
            always_ff @(posedge clk_in) begin
                if (rst_in) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                    sync3_r[gi] <= 1'b0;
                end else begin
                    sync1_r[gi] <= async_pins[gi];
                    sync2_r[gi] <= sync1_r[gi];
                    sync3_r[gi] <= sync2_r[gi];
                end
            end
        end
    endgenerate

    // digital input gating of port A; previous sample for edge and wake detection
    assign pa_gated = sync2_r[7:0] & pa_dier_r;
    assign pa_gated_prev = sync3_r[7:0] & pa_dier_r;

    ////////////////////////////////////////////////////////////////////////////
    // pin pair edge detection

    assign pair_a_now = pair_sel_r[0] ? sync2_r[`IRL_SYNC_PB5] : pa_gated[`IRL_PA_PIN0];
    assign pair_b_now = pair_sel_r[1] ? pa_gated[`IRL_PA_PIN4] : sync2_r[`IRL_SYNC_PB0];

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pair_a_prev_r <= 1'b0;
            pair_b_prev_r <= 1'b0;
        end else begin
            pair_a_prev_r <= pair_a_now;
            pair_b_prev_r <= pair_b_now;
        end
    end

    function automatic logic edge_hit(input irl_edge_t mode, input logic prev, input logic now);
        logic res;
        res = 1'b0;
        unique case (mode)
            IRL_EDGE_BOTH: res = prev != now;
            IRL_EDGE_RISE: res = !prev && now;
            IRL_EDGE_FALL: res = prev && !now;
            IRL_EDGE_RSV: res = 1'b0;
        endcase
        return res;
    endfunction

    assign pair_a_evt = edge_hit(irl_edge_t'(edge_sel_r[`IRL_EDGE_A_HI:`IRL_EDGE_A_LO]),
                                 pair_a_prev_r, pair_a_now);
    assign pair_b_evt = edge_hit(irl_edge_t'(edge_sel_r[`IRL_EDGE_B_HI:`IRL_EDGE_B_LO]),
                                 pair_b_prev_r, pair_b_now);

    ////////////////////////////////////////////////////////////////////////////
    // sixteen-bit counter

    assign cnt_bus.clk_src = irl_csrc_t'(c16_mode_r[`IRL_C16_SRC_HI:`IRL_C16_SRC_LO]);
    assign cnt_bus.prescale = c16_mode_r[`IRL_C16_DIV_HI:`IRL_C16_DIV_LO];
    assign cnt_bus.ev_sel = c16_mode_r[`IRL_C16_EVS_HI:`IRL_C16_EVS_LO];
    assign cnt_bus.fall_edge = edge_sel_r[`IRL_EDGE_C16_BIT];
    assign cnt_bus.pa0_fall = pa_gated_prev[`IRL_PA_PIN0] && !pa_gated[`IRL_PA_PIN0];
    assign cnt_bus.pa4_fall = pa_gated_prev[`IRL_PA_PIN4] && !pa_gated[`IRL_PA_PIN4];
    assign cnt_bus.fast_tick = sync2_r[`IRL_SYNC_FAST] && !sync3_r[`IRL_SYNC_FAST];
    assign cnt_bus.slow_tick = sync2_r[`IRL_SYNC_SLOW] && !sync3_r[`IRL_SYNC_SLOW];

    irl_counter16 u_counter (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .cfg(cnt_bus)
    );

    ////////////////////////////////////////////////////////////////////////////
    // source events

    always_comb begin
        pri_events = 8'h00;
        pri_events[`IRL_SRC_PAIR_A] = pair_a_evt;
        pri_events[`IRL_SRC_PAIR_B] = pair_b_evt;
        pri_events[`IRL_SRC_C16] = cnt_bus.event_pulse;
        pri_events[`IRL_SRC_CONV] = converter_done_in;
        pri_events[`IRL_SRC_CMP_PWM1] = cmp_pwm_one_evt_in;
        pri_events[`IRL_SRC_PWM0] = pwm_gen_zero_evt_in;
        pri_events[`IRL_SRC_TMR2] = timer_two_evt_in;
        pri_events[`IRL_SRC_TMR3_PWM2] = timer_three_evt_in;
    end

    assign sec_events = {touch_overflow_in, touch_complete_in};

    ////////////////////////////////////////////////////////////////////////////
    // apb decode

    assign idx = paddr_in[8:2];
    assign setup_ph = psel_in && !penable_in;
    assign wr_acc = psel_in && penable_in && pwrite_in;
    assign lane0_wr = wr_acc && pstrb_in[0];

    always_comb begin
        hit = 1'b1;
        rd_byte = 8'h00;
        unique case (idx)
            `IRL_IDX_EN_PRI: rd_byte = en_pri_r;
            `IRL_IDX_REQ_PRI: rd_byte = req_pri_r;
            `IRL_IDX_C16_MODE: rd_byte = c16_mode_r;
            `IRL_IDX_EDGE_SEL: rd_byte = 8'h00;
            `IRL_IDX_PA_DIER: rd_byte = 8'h00;
            `IRL_IDX_EN_SEC: rd_byte = {4'h0, en_sec_r, 2'h0};
            `IRL_IDX_REQ_SEC: rd_byte = {4'h0, req_sec_r, 2'h0};
            `IRL_IDX_PAIR_SEL: rd_byte = {6'h00, pair_sel_r};
            default: hit = 1'b0;
        endcase
    end

    // read data and error are captured in the setup cycle, shown in the access cycle
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (setup_ph) begin
            prdata_r <= pwrite_in ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            pslverr_r <= !hit;
        end
    end

    assign prdata_out = prdata_r;
    assign pslverr_out = pslverr_r;
    assign pready_out = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // control registers

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            en_pri_r <= `IRL_RST_EN_PRI;
        end else if (lane0_wr && hit && idx == `IRL_IDX_EN_PRI) begin
            en_pri_r <= pwdata_in[7:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            en_sec_r <= `IRL_RST_EN_SEC;
        end else if (lane0_wr && hit && idx == `IRL_IDX_EN_SEC) begin
            en_sec_r <= pwdata_in[`IRL_SEC_HI:`IRL_SEC_LO];
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            c16_mode_r <= `IRL_RST_C16_MODE;
        end else if (lane0_wr && hit && idx == `IRL_IDX_C16_MODE) begin
            c16_mode_r <= pwdata_in[7:0];
        end
    end

    // bits 7:5 are not stored, so a nonzero write there has no effect
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            edge_sel_r <= `IRL_RST_EDGE_SEL;
        end else if (lane0_wr && hit && idx == `IRL_IDX_EDGE_SEL) begin
            edge_sel_r <= pwdata_in[`IRL_EDGE_FIELD_HI:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pa_dier_r <= `IRL_RST_PA_DIER;
        end else if (lane0_wr && hit && idx == `IRL_IDX_PA_DIER) begin
            pa_dier_r <= pwdata_in[7:0] & `IRL_PA_WAKE_MASK;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pair_sel_r <= `IRL_RST_PAIR_SEL;
        end else if (lane0_wr && hit && idx == `IRL_IDX_PAIR_SEL) begin
            pair_sel_r <= pwdata_in[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // request registers: write one to clear, a new event wins over the clear

    always_comb begin
        req_pri_nxt = req_pri_r;
        if (lane0_wr && idx == `IRL_IDX_REQ_PRI) begin
            req_pri_nxt = req_pri_nxt & ~pwdata_in[7:0];
        end
        req_pri_nxt = req_pri_nxt | pri_events;
    end

    always_comb begin
        req_sec_nxt = req_sec_r;
        if (lane0_wr && idx == `IRL_IDX_REQ_SEC) begin
            req_sec_nxt = req_sec_nxt & ~pwdata_in[`IRL_SEC_HI:`IRL_SEC_LO];
        end
        req_sec_nxt = req_sec_nxt | sec_events;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            req_pri_r <= `IRL_RST_REQ;
        end else begin
            req_pri_r <= req_pri_nxt;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            req_sec_r <= 2'h0;
        end else begin
            req_sec_r <= req_sec_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(req_pri_nxt & en_pri_r) || |(req_sec_nxt & en_sec_r);
        end
    end

    // any enabled port A pin toggling raises wake for one cycle
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wake_r <= 1'b0;
        end else begin
            wake_r <= |(pa_gated ^ pa_gated_prev);
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pa_dout_r <= 8'h00;
        end else begin
            pa_dout_r <= pa_gated;
        end
    end

    assign irq_out = irq_r;
    assign wake_out = wake_r;
    assign port_a_digital_out = pa_dout_r;

endmodule

/* verilog/irl_cfg.svh */
`ifndef IRL_CFG_SVH
`define IRL_CFG_SVH

// register indices; byte address is four times the index
`define IRL_IDX_EN_PRI 7'h04
`define IRL_IDX_REQ_PRI 7'h05
`define IRL_IDX_C16_MODE 7'h06
`define IRL_IDX_EDGE_SEL 7'h0C
`define IRL_IDX_PA_DIER 7'h0D
`define IRL_IDX_EN_SEC 7'h4A
`define IRL_IDX_REQ_SEC 7'h4B
`define IRL_IDX_PAIR_SEL 7'h4C

// reset values
`define IRL_RST_EN_PRI 8'h00
`define IRL_RST_REQ 8'h00
`define IRL_RST_C16_MODE 8'h00
`define IRL_RST_EDGE_SEL 5'h00
`define IRL_RST_PA_DIER 8'hF9
`define IRL_RST_EN_SEC 2'h0
`define IRL_RST_PAIR_SEL 2'h0

// primary source bit positions
`define IRL_SRC_PAIR_A 0
`define IRL_SRC_PAIR_B 1
`define IRL_SRC_C16 2
`define IRL_SRC_CONV 3
`define IRL_SRC_CMP_PWM1 4
`define IRL_SRC_PWM0 5
`define IRL_SRC_TMR2 6
`define IRL_SRC_TMR3_PWM2 7

// secondary register fields
`define IRL_SEC_HI 3
`define IRL_SEC_LO 2
`define IRL_SEC_TOUCH_OVF 3
`define IRL_SEC_TOUCH_DONE 2

// counter mode fields
`define IRL_C16_SRC_HI 7
`define IRL_C16_SRC_LO 5
`define IRL_C16_DIV_HI 4
`define IRL_C16_DIV_LO 3
`define IRL_C16_EVS_HI 2
`define IRL_C16_EVS_LO 0
`define IRL_C16_EV_BASE 4'h8

// edge select fields
`define IRL_EDGE_C16_BIT 4
`define IRL_EDGE_B_HI 3
`define IRL_EDGE_B_LO 2
`define IRL_EDGE_A_HI 1
`define IRL_EDGE_A_LO 0
`define IRL_EDGE_FIELD_HI 4

// port A pin positions
`define IRL_PA_PIN0 0
`define IRL_PA_PIN4 4
`define IRL_PA_WAKE_MASK 8'hF9

// prescaler terminal counts for divide by 1, 4, 16, 64
`define IRL_DIV1_LAST 6'h00
`define IRL_DIV4_LAST 6'h03
`define IRL_DIV16_LAST 6'h0F
`define IRL_DIV64_LAST 6'h3F

// pin synchroniser layout
`define IRL_SYNC_W 12
`define IRL_SYNC_PB0 8
`define IRL_SYNC_PB5 9
`define IRL_SYNC_FAST 10
`define IRL_SYNC_SLOW 11

`endif

/* verilog/irl_pkg.sv */
package irl_pkg;

    typedef enum logic [2:0] {
        IRL_CSRC_OFF = 3'b000,
        IRL_CSRC_SYS = 3'b001,
        IRL_CSRC_RSV2 = 3'b010,
        IRL_CSRC_PA4_FALL = 3'b011,
        IRL_CSRC_FAST_OSC = 3'b100,
        IRL_CSRC_RSV5 = 3'b101,
        IRL_CSRC_SLOW_OSC = 3'b110,
        IRL_CSRC_PA0_FALL = 3'b111
    } irl_csrc_t;

    typedef enum logic [1:0] {
        IRL_EDGE_BOTH = 2'b00,
        IRL_EDGE_RISE = 2'b01,
        IRL_EDGE_FALL = 2'b10,
        IRL_EDGE_RSV = 2'b11
    } irl_edge_t;

endpackage

/* verilog/irl_cnt_if.sv */
`timescale 1ns/1ps
interface irl_cnt_if;
    import irl_pkg::*;
    irl_csrc_t clk_src;
    logic [1:0] prescale;
    logic [2:0] ev_sel;
    logic fall_edge;
    logic pa0_fall;
    logic pa4_fall;
    logic fast_tick;
    logic slow_tick;
    logic event_pulse;

    modport ctl (
        output clk_src, prescale, ev_sel, fall_edge, pa0_fall, pa4_fall, fast_tick, slow_tick,
        input event_pulse
    );
    modport cnt (
        input clk_src, prescale, ev_sel, fall_edge, pa0_fall, pa4_fall, fast_tick, slow_tick,
        output event_pulse
    );
endinterface

/* verilog/irl_counter16.sv */
`timescale 1ns/1ps
`include "irl_cfg.svh"
module irl_counter16
    import irl_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    irl_cnt_if.cnt cfg
);
    logic src_tick;
    logic [5:0] pre_r;
    logic [5:0] pre_last;
    logic div_tick;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic [3:0] bit_idx;
    logic event_r;

    // clock source selection
    always_comb begin
        unique case (cfg.clk_src)
            IRL_CSRC_SYS: src_tick = 1'b1;
            IRL_CSRC_PA4_FALL: src_tick = cfg.pa4_fall;
            IRL_CSRC_FAST_OSC: src_tick = cfg.fast_tick;
            IRL_CSRC_SLOW_OSC: src_tick = cfg.slow_tick;
            IRL_CSRC_PA0_FALL: src_tick = cfg.pa0_fall;
            default: src_tick = 1'b0;
        endcase
    end

    always_comb begin
        unique case (cfg.prescale)
            2'b00: pre_last = `IRL_DIV1_LAST;
            2'b01: pre_last = `IRL_DIV4_LAST;
            2'b10: pre_last = `IRL_DIV16_LAST;
            2'b11: pre_last = `IRL_DIV64_LAST;
        endcase
    end

    assign div_tick = src_tick && (pre_r >= pre_last);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pre_r <= 6'h00;
        end else if (div_tick) begin
            pre_r <= 6'h00;
        end else if (src_tick) begin
            pre_r <= pre_r + 6'h01;
        end
    end

    assign cnt_nxt = cnt_r + 16'h0001;
    assign bit_idx = `IRL_C16_EV_BASE + {1'b0, cfg.ev_sel};

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cnt_r <= 16'h0000;
        end else if (div_tick) begin
            cnt_r <= cnt_nxt;
        end
    end

    // compare the selected bit across the increment itself
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            event_r <= 1'b0;
        end else begin
            event_r <= div_tick && (cnt_r[bit_idx] != cnt_nxt[bit_idx]) &&
                (cnt_nxt[bit_idx] == ~cfg.fall_edge);
        end
    end

    assign cfg.event_pulse = event_r;
endmodule

/* verif/irl_monitor.sv */
`timescale 1ns/1ps
`include "irl_cfg.svh"
module irl_monitor (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [8:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic [7:0] evt_in,
    input wire logic irq_out,
    input wire logic [7:0] port_a_digital_out
);
    logic [6:0] idx;
    logic acc, wr_acc, mapped;
    logic [7:0] en_r;
    assign idx = paddr_in[8:2];
    assign acc = psel_in && penable_in;
    assign wr_acc = acc && pwrite_in && pstrb_in[0];
    assign mapped = idx inside {7'h04, 7'h05, 7'h06, 7'h0C, 7'h0D, 7'h4A, 7'h4B, 7'h4C};
    // shadow of the primary enable, to know which events must raise the interrupt
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            en_r <= 8'h00;
        end else if (wr_acc && idx == 7'h04) begin
            en_r <= pwdata_in[7:0];
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence s_rd;
        acc && !pwrite_in;
    endsequence
    sequence s_wr_before;
        $past(wr_acc, 3) && $past(idx, 3) == idx;
    endsequence
    property p_ready; acc |-> pready_out; endproperty
    property p_unmapped; acc && !mapped |-> pslverr_out && prdata_out == 32'h0; endproperty
    property p_mapped; acc && mapped |-> !pslverr_out; endproperty
    property p_hi_zero; s_rd |-> prdata_out[31:8] == 24'h0; endproperty
    property p_wo_zero; s_rd ##0 (idx == 7'h0C || idx == 7'h0D) |-> prdata_out == 32'h0;
    endproperty
    property p_rw_back;
        s_rd ##0 (idx == 7'h04 || idx == 7'h06) ##0 s_wr_before
            |-> prdata_out[7:0] == $past(pwdata_in[7:0], 3);
    endproperty
    property p_sec_back;
        s_rd ##0 idx == 7'h4A ##0 s_wr_before
            |-> prdata_out[7:0] == ($past(pwdata_in[7:0], 3) & 8'h0C);
    endproperty
    property p_evt_irq; (evt_in & en_r) != 8'h00 && !(wr_acc && idx == 7'h04) |=> irq_out;
    endproperty
    property p_dig_gap; port_a_digital_out[2:1] == 2'b00; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    a_unmapped: assert property (p_unmapped) else $error("no error on unmapped");
    a_mapped: assert property (p_mapped) else $error("error on mapped");
    a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
    a_wo_zero: assert property (p_wo_zero) else $error("write-only read nonzero");
    a_rw_back: assert property (p_rw_back) else $error("readback mismatch");
    a_sec_back: assert property (p_sec_back) else $error("sec enable mismatch");
    a_evt_irq: assert property (p_evt_irq) else $error("irq missing");
    a_dig_gap: assert property (p_dig_gap) else $error("pins 2:1 not zero");
endmodule
bind irl_top irl_monitor u_mon (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .evt_in({timer_three_evt_in, timer_two_evt_in, pwm_gen_zero_evt_in,
    cmp_pwm_one_evt_in, converter_done_in, 3'b000}),
    .irq_out(irq_out), .port_a_digital_out(port_a_digital_out));

/* verif/irl_core_model.sv */
`timescale 1ns/1ps
module irl_core_model (
    input wire logic clk_in,
    input wire logic pready_in,
    input wire logic [31:0] prdata_in,
    input wire logic pslverr_in,
    output logic psel_out,
    output logic penable_out,
    output logic pwrite_out,
    output logic [8:0] paddr_out,
    output logic [31:0] pwdata_out,
    output logic [3:0] pstrb_out
);
    logic [7:0] d_r;
    logic e_r;
    initial begin
        psel_out = 1'b0;
        penable_out = 1'b0;
        pwrite_out = 1'b0;
        paddr_out = 9'h000;
        pwdata_out = 32'h0;
        pstrb_out = 4'h0;
    end
    // called right after a rising edge; returns right after one
    task automatic xfer(input logic w, input logic [6:0] i, input logic [7:0] wd,
                        output logic [7:0] rd, output logic er);
        psel_out <= 1'b1;
        pwrite_out <= w;
        paddr_out <= {i, 2'b00};
        pwdata_out <= {24'h0, wd};
        pstrb_out <= 4'hF;
        @(posedge clk_in);
        penable_out <= 1'b1;
        do @(posedge clk_in); while (pready_in !== 1'b1);
        rd = prdata_in[7:0];
        er = pslverr_in;
        psel_out <= 1'b0;
        penable_out <= 1'b0;
        // released bus carries the inverted last write data
        pwdata_out <= ~pwdata_out;
        @(posedge clk_in);
    endtask
    task automatic wr_edge(input logic [7:0] v);
        xfer(1'b1, 7'h0C, {3'b000, v[4:0]}, d_r, e_r);
    endtask
    task automatic wr_dier(input logic [7:0] v);
        xfer(1'b1, 7'h0D, {v[7:3], 2'b00, v[0]}, d_r, e_r);
    endtask
endmodule

/* verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic clk_in, rst_in, psel, penable, pwrite, pready, pslverr, irq, wake, port_b0, err_v;
    logic port_b5, osc_f, osc_s;
    logic [8:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [7:0] pa, pa_dig, rd_v;
    logic [9:0] evt;
    int n_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    irl_core_model core (.clk_in(clk_in), .pready_in(pready), .prdata_in(prdata),
        .pslverr_in(pslverr), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
        .paddr_out(paddr), .pwdata_out(pwdata), .pstrb_out(pstrb));
    irl_top uut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .timer_three_evt_in(evt[7]), .timer_two_evt_in(evt[6]), .pwm_gen_zero_evt_in(evt[5]),
        .cmp_pwm_one_evt_in(evt[4]), .converter_done_in(evt[3]),
        .touch_overflow_in(evt[9]), .touch_complete_in(evt[8]), .port_a_pins_in(pa),
        .port_b_pin_zero_in(port_b0), .port_b_pin_five_in(port_b5),
        .fast_internal_osc_in(osc_f), .slow_internal_osc_in(osc_s), .irq_out(irq),
        .wake_out(wake), .port_a_digital_out(pa_dig));
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        // oscillator stand-ins: period 4 and 16 clocks
        if (cyc[0]) osc_f <= ~osc_f;
        if (cyc[2:0] == 3'h0) osc_s <= ~osc_s;
        if (cyc == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] i, input logic [7:0] d);
        core.xfer(1'b1, i, d, rd_v, err_v);
    endtask
    task automatic rd(input logic [6:0] i);
        core.xfer(1'b0, i, 8'h00, rd_v, err_v);
    endtask
    task automatic do_reset();
        rst_in <= 1'b1;
        tick(5);
        rst_in <= 1'b0;
        tick(1);
    endtask
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [6:0] ids [8] = '{7'h04, 7'h05, 7'h06, 7'h0C, 7'h0D, 7'h4A, 7'h4B, 7'h4C};
        foreach (ids[k]) begin
            rd(ids[k]);
            chk({err_v, rd_v}, 9'h000);
        end
        rd(7'h60);
        chk({err_v, rd_v}, 9'h100);
        wr(7'h4A, 8'hFF);
        rd(7'h4A);
        chk(rd_v, 8'h0C);
        wr(7'h04, 8'hA5);
        rd(7'h04);
        chk(rd_v, 8'hA5);
        pa <= 8'hFF;
        tick(4);
        chk(pa_dig, 8'hF9);
        pa <= 8'h00;
        tick(4);
        $display("t_regs done");
    endtask
    task automatic ev_case(input int b, input logic [6:0] ri, input logic [7:0] m,
                           input logic e);
        evt <= 10'h001 << b;
        tick(1);
        evt <= 10'h000;
        tick(1);
        chk(irq, e);
        rd(ri);
        chk(rd_v, m);
        wr(ri, m);
        chk(irq, 1'b0);
        rd(ri);
        chk(rd_v, 8'h00);
    endtask
    task automatic t_events();
        wr(7'h04, 8'hFF);
        wr(7'h05, 8'hFF);
        for (int b = 3; b < 8; b++) ev_case(b, 7'h05, 8'h01 << b, 1'b1);
        ev_case(9, 7'h4B, 8'h08, 1'b1);
        ev_case(8, 7'h4B, 8'h04, 1'b1);
        wr(7'h04, 8'hBF);
        ev_case(6, 7'h05, 8'h40, 1'b0);
        $display("t_events done");
    endtask
    task automatic pin_case(input logic [1:0] c);
        core.wr_edge({6'h00, c});
        wr(7'h05, 8'hFF);
        pa[0] <= 1'b1;
        tick(5);
        rd(7'h05);
        chk(rd_v[0], c == 2'b00 || c == 2'b01);
        wr(7'h05, 8'h01);
        pa[0] <= 1'b0;
        tick(5);
        rd(7'h05);
        chk(rd_v[0], c == 2'b00 || c == 2'b10);
    endtask
    task automatic t_pins();
        for (int c = 0; c < 4; c++) pin_case(c[1:0]);
        core.wr_edge(8'h00);
        core.wr_dier(8'hF8);
        wr(7'h05, 8'hFF);
        pa[0] <= 1'b1;
        tick(5);
        chk(pa_dig[0], 1'b0);
        rd(7'h05);
        chk(rd_v[0], 1'b0);
        pa[0] <= 1'b0;
        core.wr_dier(8'hF9);
        core.wr_edge(8'h04);
        port_b0 <= 1'b1;
        tick(5);
        rd(7'h05);
        chk(rd_v[1], 1'b1);
        port_b0 <= 1'b0;
        wr(7'h4C, 8'h01);
        core.wr_edge(8'h01);
        wr(7'h05, 8'hFF);
        port_b5 <= 1'b1;
        tick(5);
        rd(7'h05);
        chk(rd_v[0], 1'b1);
        wr(7'h4C, 8'h00);
        port_b5 <= 1'b0;
        $display("t_pins done");
    endtask
    task automatic wake_cnt(input int pin, input int exp);
        int n = 0;
        pa[pin] <= ~pa[pin];
        repeat (6) begin
            @(posedge clk_in);
            if (wake === 1'b1) n++;
        end
        chk(n, exp);
    endtask
    task automatic t_wake();
        wake_cnt(7, 1);
        wake_cnt(7, 1);
        core.wr_dier(8'h71);
        wake_cnt(7, 0);
        wake_cnt(3, 0);
        wake_cnt(5, 1);
        $display("t_wake done");
    endtask
    task automatic t_counter();
        logic [7:0] md [7] = '{8'h20, 8'h20, 8'h28, 8'h21, 8'h40, 8'h80, 8'hC0};
        logic eg [7] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
        int lo [7] = '{200, 450, 950, 450, 200, 950, 3900};
        int hi [7] = '{300, 560, 1100, 560, 300, 1100, 4300};
        foreach (md[k]) begin
            do_reset();
            core.wr_edge({3'b000, eg[k], 4'h0});
            wr(7'h04, 8'h04);
            wr(7'h06, md[k]);
            tick(lo[k]);
            rd(7'h05);
            chk(rd_v[2], 1'b0);
            tick(hi[k] - lo[k]);
            rd(7'h05);
            chk({irq, rd_v[2]}, {2{k != 4}});
        end
        $display("t_counter done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_in = 1'b1;
        evt = 10'h000;
        pa = 8'h00;
        port_b0 = 1'b0;
        port_b5 = 1'b0;
        osc_f = 1'b0;
        osc_s = 1'b0;
        tick(5);
        rst_in <= 1'b0;
        tick(1);
        t_regs();
        t_events();
        t_pins();
        t_wake();
        t_counter();
        report_and_stop();
    end
endmodule
